// file: inc/gpb_pkg.sv
// package: register map, field layout and constants for the pin pair b configuration block
package gpb_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0]  GPB_CFG_INDEX     = 8'hc1;
    localparam logic [7:0]  GPB_STATE_INDEX   = 8'hc2;
    localparam logic [11:0] GPB_CFG_ADDR      = {2'h0, GPB_CFG_INDEX, 2'h0};
    localparam logic [11:0] GPB_STATE_ADDR    = {2'h0, GPB_STATE_INDEX, 2'h0};

    localparam logic [15:0] GPB_CFG_RESET     = 16'h8000;
    localparam int          GPB_RSVD_POS      = 15;
    localparam logic        GPB_RSVD_VALUE    = 1'h1;

    // pwm time base, master clock periods per decode window
    localparam logic [10:0] GPB_TB_LEN_0      = 11'h010;
    localparam logic [10:0] GPB_TB_LEN_1      = 11'h040;
    localparam logic [10:0] GPB_TB_LEN_2      = 11'h100;
    localparam logic [10:0] GPB_TB_LEN_3      = 11'h400;

    localparam logic        GPB_DIR_INPUT     = 1'h0;
    localparam logic        GPB_DIR_OUTPUT    = 1'h1;
    localparam logic        GPB_FMT_STATIC    = 1'h0;
    localparam logic        GPB_FMT_PWM       = 1'h1;

    // bits 14:0 of the configuration word, msb first
    typedef struct packed {
        logic [2:0] spare_hi;
        logic       pin_one_input_format;
        logic       pin_zero_input_format;
        logic       pin_one_direction;
        logic       pin_zero_direction;
        logic [1:0] pin_one_pwm_timebase;
        logic [1:0] pin_zero_pwm_timebase;
        logic [1:0] spare_lo;
        logic       pin_one_out_data;
        logic       pin_zero_out_data;
    } gpb_cfg_s;

    localparam gpb_cfg_s    GPB_CFG_FIELDS_RESET = gpb_cfg_s'(GPB_CFG_RESET[14:0]);

    // one pin's pad signals
    typedef struct packed {
        logic o;
        logic oe;
    } gpb_pad_s;
endpackage : gpb_pkg

// file: rtl/gpb_config.sv
// pin pair b configuration: apb register, direction, static or pwm-decoded input, static output
//
// Operation
// - five spare bits, read/write, no effect
// - pin one format: static or pwm input
// - pin one output always static level
// - pin zero format: static or pwm input
// - pin zero output always static level
// - pin one direction: zero input, one output
// - pin zero direction: zero input, one output
// - pwm time base 16/64/256/1024 clocks
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module gpb_config (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 pin_zero_i,
    input  wire logic                 pin_one_i,
    output gpb_pkg::gpb_pad_s         pin_zero_pad,
    output gpb_pkg::gpb_pad_s         pin_one_pad,
    output logic      [1:0]           pin_level
);
    import gpb_pkg::*;

    function automatic logic [10:0] tb_len(input logic [1:0] code);
        case (code)
            2'h0:    tb_len = GPB_TB_LEN_0;
            2'h1:    tb_len = GPB_TB_LEN_1;
            2'h2:    tb_len = GPB_TB_LEN_2;
            default: tb_len = GPB_TB_LEN_3;
        endcase
    endfunction : tb_len

    function automatic logic [31:0] cfg_word(input gpb_cfg_s c);
        logic [31:0] w;
        w = {16'h0000, GPB_RSVD_VALUE, c};
        cfg_word = w;
    endfunction : cfg_word

    // window closes on its last clock; a shorter time base picked after the window ran past its length closes it at once
    function automatic logic window_end(input logic [10:0] win, input logic [10:0] len);
        window_end = (win >= len - 11'h001);
    endfunction : window_end

    // strictly more than half the window high reads high, so an even split reads low
    function automatic logic pwm_level(input logic [10:0] highs, input logic [10:0] len);
        pwm_level = (highs > {1'h0, len[10:1]});
    endfunction : pwm_level

    // ---------------- apb slave ----------------
    gpb_cfg_s    cfg_r;
    gpb_cfg_s    cfg_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic        hit_cfg;
    logic        hit_state;
    logic        access;
    logic        commit;
    logic [1:0]  level_r;
    logic [1:0]  level_nxt;

    // one wait state: pready rises in the second access cycle, registers update at that edge
    always_comb begin
        hit_cfg     = (paddr == GPB_CFG_ADDR);
        hit_state   = (paddr == GPB_STATE_ADDR);
        access      = psel & penable & ~pready_r;
        commit      = psel & penable & pready_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'h0;
        pready_nxt  = access;
        if (access) begin
            // state register is read-only; anything off the map is refused
            pslverr_nxt = ~(hit_cfg | hit_state) | (pwrite & hit_state);
            if (pwrite) begin
                prdata_nxt = 32'h0000_0000;
            end else if (hit_cfg) begin
                prdata_nxt = cfg_word(cfg_r);
            end else if (hit_state) begin
                prdata_nxt = {30'h0, level_r};
            end else begin
                prdata_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'h0;
            pslverr_r <= 1'h0;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ---------------- configuration register ----------------
    // stored only at the edge that completes the access, never on the wait cycle;
    // write data above bit 14 is dropped since bit 15 is a constant one
    always_comb begin
        cfg_nxt = cfg_r;
        if (commit && pwrite && hit_cfg) begin
            cfg_nxt = gpb_cfg_s'(pwdata[GPB_RSVD_POS-1:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_r <= GPB_CFG_FIELDS_RESET;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ---------------- field split ----------------
    // pin one in bit 1, pin zero in bit 0 throughout
    logic [1:0]       dir;
    logic [1:0]       fmt;
    logic [1:0]       dat;
    logic [1:0]       pin_in;
    logic [1:0][1:0]  tb;

    always_comb begin
        dir    = {cfg_r.pin_one_direction, cfg_r.pin_zero_direction};
        fmt    = {cfg_r.pin_one_input_format, cfg_r.pin_zero_input_format};
        dat    = {cfg_r.pin_one_out_data, cfg_r.pin_zero_out_data};
        tb     = {cfg_r.pin_one_pwm_timebase, cfg_r.pin_zero_pwm_timebase};
        pin_in = {pin_one_i, pin_zero_i};
    end

    // ---------------- pad drivers ----------------
    gpb_pad_s [1:0]   pad_r;
    gpb_pad_s [1:0]   pad_nxt;

    // oe and o switch at one edge, so a pin that stays driven never sees a runt
    always_comb begin
        pad_nxt = pad_r;
        for (int i = 0; i < 2; i++) begin
            // format is ignored when driving: no pwm output exists on either pin
            pad_nxt[i].oe = (dir[i] == GPB_DIR_OUTPUT);
            // o held low while an input, so a turn to output starts from a known level
            pad_nxt[i].o  = dat[i] & (dir[i] == GPB_DIR_OUTPUT);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pad_r <= '0;
        end else begin
            pad_r <= pad_nxt;
        end
    end

    assign pin_zero_pad = pad_r[0];
    assign pin_one_pad  = pad_r[1];

    // ---------------- input decoders ----------------
    // counters are 11 bits: a 1024-clock window of all highs must not wrap
    logic [1:0][10:0] win_r;
    logic [1:0][10:0] win_nxt;
    logic [1:0][10:0] high_r;
    logic [1:0][10:0] high_nxt;
    logic [10:0]      len;
    logic [10:0]      total;

    // a time base change acts on the running window, it does not restart it
    always_comb begin
        len       = 11'h000;
        total     = 11'h000;
        win_nxt   = win_r;
        high_nxt  = high_r;
        level_nxt = level_r;
        for (int i = 0; i < 2; i++) begin
            len   = tb_len(tb[i]);
            total = high_r[i] + {10'h000, pin_in[i]};
            if (dir[i] == GPB_DIR_INPUT && fmt[i] == GPB_FMT_PWM) begin
                // duty above half of the window decodes as high
                if (window_end(win_r[i], len)) begin
                    level_nxt[i] = pwm_level(total, len);
                    win_nxt[i]   = 11'h000;
                    high_nxt[i]  = 11'h000;
                end else begin
                    win_nxt[i]  = win_r[i] + 11'h001;
                    high_nxt[i] = total;
                end
            end else begin
                // static sampling; window restarts when pwm is selected again
                level_nxt[i] = pin_in[i];
                win_nxt[i]   = 11'h000;
                high_nxt[i]  = 11'h000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            win_r   <= '0;
            high_r  <= '0;
            level_r <= 2'h0;
        end else begin
            win_r   <= win_nxt;
            high_r  <= high_nxt;
            level_r <= level_nxt;
        end
    end

    assign pin_level = level_r;
endmodule : gpb_config

// file: sim/gpb_config_props.sv
// checker: port-level assertions for the pin pair b configuration block
`timescale 1ns/1ps
module gpb_config_props (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire gpb_pkg::gpb_pad_s pin_zero_pad,
    input wire gpb_pkg::gpb_pad_s pin_one_pad
);
    import gpb_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_acc; psel && penable && pready; endsequence
    sequence s_wr; s_acc ##0 pwrite && paddr == GPB_CFG_ADDR; endsequence
    a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_zero_dir: assert property (s_wr |-> ##2 pin_zero_pad.oe == $past(pwdata[8], 2))
        else $error("pin zero direction");
    a_one_dir: assert property (s_wr |-> ##2 pin_one_pad.oe == $past(pwdata[9], 2))
        else $error("pin one direction");
    a_zero_static: assert property (s_wr ##0 pwdata[8] |-> ##2 pin_zero_pad.o == $past(pwdata[0], 2))
        else $error("pin zero level");
    a_one_static: assert property (s_wr ##0 pwdata[9] |-> ##2 pin_one_pad.o == $past(pwdata[1], 2))
        else $error("pin one level");
    a_cfg_read: assert property (s_acc ##0 !pwrite && paddr == GPB_CFG_ADDR |-> prdata[31:15] == 17'h1)
        else $error("config read upper bits");
    a_unmapped_err: assert property (s_acc ##0 paddr != GPB_CFG_ADDR && paddr != GPB_STATE_ADDR |-> pslverr)
        else $error("unmapped not refused");
    a_out_steady: assert property (pin_zero_pad.oe && $changed(pin_zero_pad.o) |-> $past(pwrite && pready, 2))
        else $error("output glitch");
endmodule : gpb_config_props
bind gpb_config gpb_config_props i_props (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_zero_pad(pin_zero_pad), .pin_one_pad(pin_one_pad));

// file: sim/gpb_pin_drv.sv
// partner: external drivers on the two pins, static level or 16-clock pwm
`timescale 1ns/1ps
module gpb_pin_drv (
    input  wire logic              ref_clk,
    input  wire logic [1:0]        pwm_sel,
    input  wire logic [1:0]        lvl,
    input  wire logic [4:0]        duty,
    input  wire gpb_pkg::gpb_pad_s pin_zero_pad,
    input  wire gpb_pkg::gpb_pad_s pin_one_pad,
    output logic                   pin_zero_i,
    output logic                   pin_one_i
);
    logic [3:0] ph_r = 4'h0;
    logic [1:0] ext;
    always_ff @(posedge ref_clk) ph_r <= ph_r + 4'h1;
    // period 16 so any window of 16, 64, 256 or 1024 sees the same duty
    assign ext = (pwm_sel & {2{ph_r < duty}}) | (~pwm_sel & lvl);
    // a driving pad wins the wire
    assign pin_zero_i = pin_zero_pad.oe ? pin_zero_pad.o : ext[0];
    assign pin_one_i = pin_one_pad.oe ? pin_one_pad.o : ext[1];
endmodule : gpb_pin_drv

// file: sim/tb_top.sv
// testbench: apb access and pin behaviour of the pin pair b configuration block
`timescale 1ns/1ps
module tb_top;
    import gpb_pkg::*;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, pin_zero_i, pin_one_i;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] pin_level, pwm_sel = 2'h0, lvl = 2'h0;
    logic [4:0] duty = 5'h0;
    gpb_pad_s pin_zero_pad, pin_one_pad;
    int n_fail = 0, tests_run = 0;
    always #2.5 ref_clk = ~ref_clk;
    gpb_config i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_zero_i(pin_zero_i), .pin_one_i(pin_one_i), .pin_zero_pad(pin_zero_pad),
        .pin_one_pad(pin_one_pad), .pin_level(pin_level));
    gpb_pin_drv i_pins (.ref_clk(ref_clk), .pwm_sel(pwm_sel), .lvl(lvl), .duty(duty),
        .pin_zero_pad(pin_zero_pad), .pin_one_pad(pin_one_pad), .pin_zero_i(pin_zero_i), .pin_one_i(pin_one_i));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge ref_clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) n_fail++;
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        apb(0, GPB_CFG_ADDR, 0);
        chk(rd, 32'h8000);
        apb(1, GPB_CFG_ADDR, 32'hffff70fc);
        apb(0, GPB_CFG_ADDR, 0);
        chk(rd, 32'hf0fc);
        apb(0, 12'h300, 0);
        chk({rd[30:0], er}, 32'h1);
        apb(1, GPB_STATE_ADDR, 3);
        chk(32'(er), 32'h1);
        $display("register test done");
        apb(1, GPB_CFG_ADDR, 32'h0f01);
        repeat (3) @(posedge ref_clk);
        chk(32'({pin_one_pad, pin_zero_pad}), 32'h7);
        apb(1, GPB_CFG_ADDR, 32'h0f02);
        repeat (3) @(posedge ref_clk);
        chk(32'({pin_one_pad, pin_zero_pad}), 32'hd);
        $display("output test done");
        lvl <= 2'h1;
        apb(1, GPB_CFG_ADDR, 0);
        repeat (5) @(posedge ref_clk);
        chk(32'(pin_level), 32'h1);
        apb(0, GPB_STATE_ADDR, 0);
        chk(rd, 32'h1);
        $display("static input test done");
        pwm_sel <= 2'h3;
        for (int c = 0; c < 4; c++) begin
            apb(1, GPB_CFG_ADDR, 32'h0c00 | (c * 32'h50));
            duty <= 5'h0c;
            repeat ((32 << (2 * c)) + 20) @(posedge ref_clk);
            chk(32'(pin_level), 32'h3);
            duty <= 5'h04;
            repeat ((32 << (2 * c)) + 20) @(posedge ref_clk);
            chk(32'(pin_level), 32'h0);
        end
        $display("pwm input test done");
        apb(1, GPB_CFG_ADDR, 32'h7f03);
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        apb(0, GPB_CFG_ADDR, 0);
        chk(rd, 32'h8000);
        chk(32'({pin_one_pad, pin_zero_pad}), 32'h0);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule : tb_top
